// *** design/fsbl_lock_reg.sv ***
`timescale 1ns/1ps
// One block's lock register: write lock, lock-down and read lock.
module fsbl_lock_reg (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] lockValue
);
  logic [2:0] lock_ff;
  logic [2:0] nxt_lock;
  logic downNow;

  // Lock-down freezes all three bits until reset; lock-down is sticky.
  assign downNow = lock_ff[fsbl_pkg::LOCK_DOWN];
  assign nxt_lock = (wrEn && !downNow) ?
      {wrData[fsbl_pkg::LOCK_READ], wrData[fsbl_pkg::LOCK_DOWN], wrData[fsbl_pkg::LOCK_WRITE]}
      : lock_ff;

  // Reset leaves the block write-protected, readable and unlocked.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_ff <= fsbl_pkg::LOCK_RESET[2:0];
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  // Reserved bits 7 to 3 read as zero.
  assign lockValue = {5'h00, lock_ff};

  a_down_freezes: assert property (@(posedge clk) disable iff (!nrst)
    downNow |=> lock_ff == $past(lock_ff)
  ) else $error("lock changed under lock-down");
  a_down_sticky: assert property (@(posedge clk) disable iff (!nrst)
    downNow |=> downNow
  ) else $error("lock-down cleared without reset");
  a_write_takes: assert property (@(posedge clk) disable iff (!nrst)
    (wrEn && !downNow) |=> lockValue[2:0] == $past(wrData[2:0])
  ) else $error("lock write not taken");
endmodule // fsbl_lock_reg

// *** design/fsbl_pkg.sv ***
package fsbl_pkg;
  // Status register bit positions.
  localparam int STAT_READY = 7;
  localparam int STAT_ERS_SUSP = 6;
  localparam int STAT_ERS_FAIL = 5;
  localparam int STAT_PRG_FAIL = 4;
  localparam int STAT_RSVD3 = 3;
  localparam int STAT_PRG_SUSP = 2;
  localparam int STAT_PROT_VIOL = 1;
  localparam int STAT_RSVD0 = 0;
  // Lock register bit positions.
  localparam int LOCK_WRITE = 0;
  localparam int LOCK_DOWN = 1;
  localparam int LOCK_READ = 2;
  // Block count and the top block index.
  localparam int NUM_BLOCKS = 8;
  localparam int TOP_BLOCK = 7;
  // Values after reset.
  localparam logic [7:0] LOCK_RESET = 8'h01;
  localparam logic [7:0] STAT_RESET = 8'h80;
  // Data that a read-locked block returns.
  localparam logic [7:0] READ_BLANK = 8'h00;
endpackage

// *** design/fsbl_status_lock.sv ***
`timescale 1ns/1ps
// Contract
// - Resume clears erase-suspended flag.
// - Erase failure flag set on max pulses.
// - Erase failure sticky until clear or reset.
// - Program failure flag set on max pulses.
// - Program failure sticky until clear or reset.
// - Erase-suspended reads one during suspended-erase program.
// - LPC protection reject sets ready and violation only.
// - Cell failure sets ready and matching flag.
// - Program-suspended flag set when program paused.
// - Resume clears program-suspended flag.
// - Protection violation sticky until clear or reset; the code also clears it while muxMode is high.
// - Mux interface reads violation as zero.
// - Each block has readable writable lock register.
// - Write lock refuses program and erase.
// - Top guard pin low protects top block.
// - Main guard pin low protects main blocks.
// - Reset sets every write lock.
// - Read lock makes array reads return zero.
// - Reset clears every read lock.
// - Lock-down freezes lock register until reset.
// - Clear-status resets bits 1, 3, 4, 5.
// - Ready is zero while controller busy.
// - Lock bits 0,1,2; lock-down not clearable.
module fsbl_status_lock (
  input wire logic clk,
  input wire logic nrst,
  input wire logic muxMode,
  input wire logic topBlockGuardPin,
  input wire logic mainBlockGuardPin,
  input wire logic opStart,
  input wire logic opIsErase,
  input wire logic [2:0] opBlock,
  input wire logic opDone,
  input wire logic opFail,
  input wire logic suspendReq,
  input wire logic pauseReached,
  input wire logic resumeCmd,
  input wire logic clearStatusCmd,
  input wire logic lockWrEn,
  input wire logic [2:0] lockWrBlock,
  input wire logic [7:0] lockWrData,
  input wire logic [2:0] lockRdBlock,
  input wire logic [2:0] arrayRdBlock,
  input wire logic [7:0] arrayRdData,
  output logic [7:0] statusOut,
  output logic [7:0] lockRdData,
  output logic [7:0] arrayDataOut,
  output logic opGranted
);
  ////////////////////////////////////////////////////////////////////////////
  // Lock registers, one per block.
  logic [7:0] lockVal [fsbl_pkg::NUM_BLOCKS];
  logic [fsbl_pkg::NUM_BLOCKS-1:0] wLock;
  logic [fsbl_pkg::NUM_BLOCKS-1:0] rLock;

  // Each block gets its own lock register instance.
  for (genvar b = 0; b < fsbl_pkg::NUM_BLOCKS; b++) begin : gLock
    fsbl_lock_reg uLock (
      .clk(clk),
      .nrst(nrst),
      .wrEn(lockWrEn && (lockWrBlock == 3'(b))),
      .wrData(lockWrData),
      .lockValue(lockVal[b])
    );
    assign wLock[b] = lockVal[b][fsbl_pkg::LOCK_WRITE];
    assign rLock[b] = lockVal[b][fsbl_pkg::LOCK_READ];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection decode for the requested block.
  logic isTop;
  logic blockProtected;
  logic opRejected;
  logic opAccepted;
  assign isTop = (opBlock == 3'(fsbl_pkg::TOP_BLOCK));
  // Lock register and guard pins are ORed; either one alone protects the block.
  assign blockProtected = wLock[opBlock]
      || (isTop && !topBlockGuardPin)
      || (!isTop && !mainBlockGuardPin);
  // Status register, declared here because the request decode reads its flags.
  logic [7:0] status_ff;
  // A request while a failure or violation flag is pending is refused and never granted.
  logic flagsPending;
  assign flagsPending = status_ff[fsbl_pkg::STAT_ERS_FAIL] || status_ff[fsbl_pkg::STAT_PRG_FAIL]
      || status_ff[fsbl_pkg::STAT_PROT_VIOL];
  assign opRejected = opStart && blockProtected;
  assign opAccepted = opStart && !blockProtected && !flagsPending;

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine.
  // Gray codes along idle, busy, suspending, paused, nested; three codes stay unused.
  typedef enum logic [2:0] {
    FSBL_IDLE = 3'b000,
    FSBL_BUSY = 3'b001,
    FSBL_SUSPENDING = 3'b011,
    FSBL_PAUSED = 3'b010,
    FSBL_NESTED = 3'b110
  } fsbl_state_e;
  fsbl_state_e state_ff;
  fsbl_state_e nxtState;
  logic eraseOp_ff;
  logic [7:0] nxtStatus;
  logic nestedDone;

  // Program during erase suspension runs nested; its end returns to the paused erase.
  assign nestedDone = (state_ff == FSBL_NESTED) && opDone;

  // A paused program takes no new work; only a paused erase lets a program in.
  always_comb begin
    nxtState = state_ff;
    unique case (state_ff)
      FSBL_IDLE: begin
        if (opAccepted) nxtState = FSBL_BUSY;
      end
      FSBL_BUSY: begin
        if (opDone) nxtState = FSBL_IDLE;
        else if (suspendReq) nxtState = FSBL_SUSPENDING;
      end
      FSBL_SUSPENDING: begin
        // The operation may finish instead of pausing.
        if (opDone) nxtState = FSBL_IDLE;
        else if (pauseReached) nxtState = FSBL_PAUSED;
      end
      FSBL_PAUSED: begin
        if (resumeCmd) nxtState = FSBL_BUSY;
        else if (eraseOp_ff && opAccepted && !opIsErase) nxtState = FSBL_NESTED;
      end
      FSBL_NESTED: begin
        if (opDone) nxtState = FSBL_PAUSED;
      end
      default: nxtState = FSBL_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status next value.
  always_comb begin
    nxtStatus = status_ff;
    // Clear-status resets bits 1, 3, 4 and 5; a same-cycle set below wins.
    if (clearStatusCmd) begin
      nxtStatus[fsbl_pkg::STAT_PROT_VIOL] = 1'b0;
      nxtStatus[fsbl_pkg::STAT_RSVD3] = 1'b0;
      nxtStatus[fsbl_pkg::STAT_PRG_FAIL] = 1'b0;
      nxtStatus[fsbl_pkg::STAT_ERS_FAIL] = 1'b0;
    end
    // Ready only when idle or paused.
    nxtStatus[fsbl_pkg::STAT_READY] = (nxtState == FSBL_IDLE) || (nxtState == FSBL_PAUSED);
    // Suspend flags follow the paused/nested state; resume drops them.
    nxtStatus[fsbl_pkg::STAT_ERS_SUSP] = eraseOp_ff &&
        ((nxtState == FSBL_PAUSED) || (nxtState == FSBL_NESTED));
    nxtStatus[fsbl_pkg::STAT_PRG_SUSP] = !eraseOp_ff && (nxtState == FSBL_PAUSED);
    // Cell failure sets only the matching flag; sticky until clear.
    if (opDone && opFail && (state_ff != FSBL_IDLE) && (state_ff != FSBL_PAUSED)) begin
      if (eraseOp_ff && !nestedDone) nxtStatus[fsbl_pkg::STAT_ERS_FAIL] = 1'b1;
      else nxtStatus[fsbl_pkg::STAT_PRG_FAIL] = 1'b1;
    end
    // Protection reject on LPC sets violation; mux mode never shows it.
    if (opRejected && !muxMode) nxtStatus[fsbl_pkg::STAT_PROT_VIOL] = 1'b1;
    if (muxMode) nxtStatus[fsbl_pkg::STAT_PROT_VIOL] = 1'b0;
    // Bit 0 is reserved and reads zero; bit 3 is never set, so it reads zero too.
    nxtStatus[fsbl_pkg::STAT_RSVD0] = 1'b0;
  end

  // State, operation type and status registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= FSBL_IDLE;
      eraseOp_ff <= 1'b0;
      status_ff <= fsbl_pkg::STAT_RESET;
    end else begin
      state_ff <= nxtState;
      status_ff <= nxtStatus;
      if (state_ff == FSBL_IDLE && opAccepted) eraseOp_ff <= opIsErase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read paths and grant pulse.
  logic [7:0] nxtArray;
  logic opTaken;
  // Grant only a real launch: from idle, or a program nested into a paused erase.
  // A request that meets a resume or the end of running work is not granted.
  assign opTaken = opAccepted && (((state_ff == FSBL_IDLE) && (nxtState == FSBL_BUSY))
      || ((state_ff == FSBL_PAUSED) && (nxtState == FSBL_NESTED)));
  // A read-locked block returns zero instead of its data.
  assign nxtArray = rLock[arrayRdBlock] ? fsbl_pkg::READ_BLANK : arrayRdData;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lockRdData <= 8'h00;
      arrayDataOut <= 8'h00;
      opGranted <= 1'b0;
    end else begin
      lockRdData <= lockVal[lockRdBlock];
      arrayDataOut <= nxtArray;
      opGranted <= opTaken;
    end
  end

  assign statusOut = status_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Suspend and resume flags follow the controller state.
  a_resume_clears: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FSBL_PAUSED && resumeCmd) |=> !statusOut[6] && !statusOut[2]
  ) else $error("suspend flag survived resume");
  a_nested_susp: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FSBL_NESTED) |-> statusOut[6] && !statusOut[7]
  ) else $error("nested program without erase suspend flag");
  a_plain_prog: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FSBL_BUSY && !eraseOp_ff) |-> !statusOut[6]
  ) else $error("erase suspend flag during plain program");
  a_prog_paused: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FSBL_PAUSED && !eraseOp_ff) |-> statusOut[2] && statusOut[7]
  ) else $error("paused program not flagged");
  a_prog_resume: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FSBL_PAUSED && !eraseOp_ff && resumeCmd) |=> !statusOut[2]
  ) else $error("program suspend flag survived resume");

  // Failure flags: set by the matching operation, kept until a clear.
  // Busy or winding down to a pause; a failure here belongs to the running operation.
  logic runState;
  assign runState = (state_ff == FSBL_BUSY) || (state_ff == FSBL_SUSPENDING);
  a_erase_fail_set: assert property (@(posedge clk) disable iff (!nrst)
    (opDone && opFail && eraseOp_ff && runState) |=> statusOut[5]
  ) else $error("erase failure not flagged");
  a_prog_fail_set: assert property (@(posedge clk) disable iff (!nrst)
    (opDone && opFail && ((!eraseOp_ff && runState) || nestedDone)) |=> statusOut[4]
  ) else $error("program failure not flagged");
  a_fail_matching: assert property (@(posedge clk) disable iff (!nrst)
    (opDone && opFail && !eraseOp_ff && runState && !statusOut[5]) |=> statusOut[7:5] == 3'h4
  ) else $error("cell failure set the wrong flags");
  a_fail_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (statusOut[5] && !clearStatusCmd) |=> statusOut[5]
  ) else $error("erase fail lost");
  a_pfail_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (statusOut[4] && !clearStatusCmd) |=> statusOut[4]
  ) else $error("program fail lost");

  // Protection: lock bits and guard pins refuse work, the violation flag reports it.
  a_prot_sets: assert property (@(posedge clk) disable iff (!nrst)
    (opRejected && !muxMode) |=> statusOut[1] && !opGranted
  ) else $error("no violation");
  a_reject_flags: assert property (@(posedge clk) disable iff (!nrst)
    (opRejected && !muxMode && state_ff == FSBL_IDLE && !flagsPending) |=> statusOut[7:4] == 4'h8
  ) else $error("protection reject touched other flags");
  a_prot_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (statusOut[1] && !clearStatusCmd && !muxMode) |=> statusOut[1]
  ) else $error("violation flag lost");
  a_mux_noviol: assert property (@(posedge clk) disable iff (!nrst)
    muxMode |=> !statusOut[1]
  ) else $error("violation in mux mode");
  a_write_lock: assert property (@(posedge clk) disable iff (!nrst)
    (opStart && wLock[opBlock]) |=> !opGranted
  ) else $error("write-locked block granted");
  a_open_grant: assert property (@(posedge clk) disable iff (!nrst)
    (opStart && !blockProtected && !flagsPending && state_ff == FSBL_IDLE) |=> opGranted
  ) else $error("open block not granted");
  a_pending_nogrant: assert property (@(posedge clk) disable iff (!nrst)
    (opStart && flagsPending) |=> !opGranted
  ) else $error("granted with a failure flag pending");
  a_top_guard: assert property (@(posedge clk) disable iff (!nrst)
    (opStart && isTop && !topBlockGuardPin) |=> !opGranted
  ) else $error("top guard");
  a_main_guard: assert property (@(posedge clk) disable iff (!nrst)
    (opStart && !isTop && !mainBlockGuardPin) |=> !opGranted
  ) else $error("main guard");

  // Read path, readiness and clear-status.
  a_read_blank: assert property (@(posedge clk) disable iff (!nrst)
    rLock[arrayRdBlock] |=> arrayDataOut == 8'h00
  ) else $error("read lock leak");
  a_read_open: assert property (@(posedge clk) disable iff (!nrst)
    !rLock[arrayRdBlock] |=> arrayDataOut == $past(arrayRdData)
  ) else $error("open block read wrong");
  a_busy_ready: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FSBL_BUSY) |-> !statusOut[7]
  ) else $error("ready while busy");
  a_susp_notready: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FSBL_SUSPENDING) |-> !statusOut[7]
  ) else $error("ready before the pause");
  a_idle_ready: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FSBL_IDLE || state_ff == FSBL_PAUSED) |-> statusOut[7]
  ) else $error("not ready while idle or paused");
  a_granted_busy: assert property (@(posedge clk) disable iff (!nrst)
    opGranted |-> !statusOut[7]
  ) else $error("ready on grant");
  a_clear_bits: assert property (@(posedge clk) disable iff (!nrst)
    (clearStatusCmd && !opDone && !opRejected) |=> statusOut[5:3] == 3'h0 && !statusOut[1]
  ) else $error("clear status missed");

  // Main scenarios reached by the bench.
  c_erase_done: cover property (@(posedge clk) disable iff (!nrst)
    state_ff == FSBL_BUSY && eraseOp_ff ##1 state_ff == FSBL_IDLE);
  c_nested: cover property (@(posedge clk) disable iff (!nrst) state_ff == FSBL_NESTED);
  c_reject: cover property (@(posedge clk) disable iff (!nrst) opRejected);
  c_prog_paused: cover property (@(posedge clk) disable iff (!nrst)
    state_ff == FSBL_PAUSED && !eraseOp_ff);
endmodule // fsbl_status_lock

// *** tb/flash_status_and_block_lock_tb.sv ***
`timescale 1ns/1ps
module flash_status_and_block_lock_tb;
  logic clk = 1'h0, nrst = 1'h0, muxMode = 1'h0, topBlockGuardPin = 1'h1;
  logic mainBlockGuardPin = 1'h1, opStart = 1'h0, opIsErase = 1'h0, suspendReq = 1'h0;
  logic resumeCmd = 1'h0, clearStatusCmd = 1'h0, lockWrEn = 1'h0, failSel = 1'h0;
  logic opDone, opFail, pauseReached, opGranted;
  logic [2:0] opBlock = 3'h0, lockWrBlock = 3'h0, lockRdBlock = 3'h0, arrayRdBlock = 3'h0, b;
  logic [7:0] lockWrData = 8'h00, arrayRdData = 8'h00, lat = 8'h14;
  logic [7:0] statusOut, lockRdData, arrayDataOut;
  logic [7:0] lk [8];
  int err_total = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  fsbl_status_lock i_fsbl_status_lock (.clk, .nrst, .muxMode, .topBlockGuardPin,
    .mainBlockGuardPin, .opStart, .opIsErase, .opBlock, .opDone, .opFail, .suspendReq,
    .pauseReached, .resumeCmd, .clearStatusCmd, .lockWrEn, .lockWrBlock, .lockWrData,
    .lockRdBlock, .arrayRdBlock, .arrayRdData, .statusOut, .lockRdData, .arrayDataOut,
    .opGranted);
  fsbl_algo_model i_fsbl_algo_model (.clk, .nrst, .opGranted, .suspendReq, .resumeCmd,
    .lat, .failSel, .opDone, .opFail, .pauseReached);
  ////////////////////////////////////////////////////////////////////////////////
  // Waits end one step past the edge, so the design's updates have landed.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reserved bits 3 and 0 carry no meaning, so they are masked.
  task automatic stat(input logic [7:0] e);
    chk("status", e, statusOut & 8'hF6);
  endtask
  task automatic start(input logic er, input logic [2:0] blk, input logic g);
    @(posedge clk);
    {opStart, opIsErase, opBlock} <= {1'h1, er, blk};
    @(posedge clk);
    opStart <= 1'h0;
    cyc(0);
    chk("grant", {7'h00, g}, {7'h00, opGranted});
    cyc(1);
  endtask
  // Command bits are clear, suspend, resume from high to low.
  task automatic cmd(input logic [2:0] k);
    @(posedge clk);
    {clearStatusCmd, suspendReq, resumeCmd} <= k;
    @(posedge clk);
    {clearStatusCmd, suspendReq, resumeCmd} <= 3'h0;
    cyc(2);
  endtask
  task automatic lockWr(input logic [2:0] blk, input logic [7:0] d);
    @(posedge clk);
    {lockWrEn, lockWrBlock, lockWrData} <= {1'h1, blk, d};
    @(posedge clk);
    lockWrEn <= 1'h0;
    lk[blk] = lk[blk][1] ? lk[blk] : d;
  endtask
  function automatic logic [7:0] expRd(input logic [2:0] blk, input logic [7:0] d);
    return lk[blk][2] ? 8'h00 : d;
  endfunction
  task automatic lockRd(input logic [2:0] blk);
    @(posedge clk);
    {lockRdBlock, arrayRdBlock, arrayRdData} <= {blk, blk, 8'($urandom)};
    cyc(2);
    chk("lock", lk[blk], lockRdData);
    chk("array", expRd(blk, arrayRdData), arrayDataOut);
  endtask
  task automatic waitRdy;
    int i;
    for (i = 0; i < 300 && statusOut[7] !== 1'h1; i++) cyc(1);
    if (i == 300) begin
      err_total++;
      conclude;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: protection, failures, suspends, guard pins, lock-down, reset.
  initial begin
    void'($urandom(32'hc406));
    foreach (lk[i]) lk[i] = 8'h01;
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    cyc(1);
    stat(8'h80);
    for (int i = 0; i < 8; i++) lockRd(3'(i));
    start(1'h0, 3'h3, 1'h0);
    stat(8'h82);
    start(1'h1, 3'h3, 1'h0);
    cmd(3'h4);
    stat(8'h80);
    @(posedge clk) muxMode <= 1'h1;
    start(1'h0, 3'h3, 1'h0);
    stat(8'h80);
    @(posedge clk) muxMode <= 1'h0;
    repeat (24) begin
      b = 3'($urandom_range(7));
      lockWr(b, 8'($urandom) & 8'h05);
      lockRd(b);
    end
    for (int i = 0; i < 8; i++) lockWr(3'(i), 8'h00);
    @(posedge clk) {failSel, lat} <= {1'h1, 8'h02};
    start(1'h0, 3'h3, 1'h1);
    stat(8'h00);
    waitRdy;
    stat(8'h90);
    start(1'h1, 3'h3, 1'h0);
    stat(8'h90);
    cmd(3'h4);
    start(1'h1, 3'h4, 1'h1);
    waitRdy;
    stat(8'hA0);
    start(1'h0, 3'h4, 1'h0);
    cmd(3'h4);
    @(posedge clk) {failSel, lat} <= {1'h0, 8'h1E};
    start(1'h1, 3'h4, 1'h1);
    waitRdy;
    stat(8'h80);
    start(1'h1, 3'h5, 1'h1);
    cmd(3'h2);
    stat(8'hC0);
    start(1'h0, 3'h6, 1'h1);
    stat(8'h40);
    waitRdy;
    stat(8'hC0);
    cmd(3'h1);
    waitRdy;
    stat(8'h80);
    start(1'h0, 3'h6, 1'h1);
    cmd(3'h2);
    stat(8'h84);
    cmd(3'h1);
    stat(8'h00);
    waitRdy;
    @(posedge clk) topBlockGuardPin <= 1'h0;
    start(1'h0, 3'h7, 1'h0);
    stat(8'h82);
    cmd(3'h4);
    @(posedge clk) {topBlockGuardPin, mainBlockGuardPin} <= 2'h2;
    start(1'h1, 3'h0, 1'h0);
    start(1'h0, 3'h7, 1'h0);
    cmd(3'h4);
    @(posedge clk) mainBlockGuardPin <= 1'h1;
    start(1'h0, 3'h7, 1'h1);
    waitRdy;
    lockWr(3'h1, 8'h06);
    lockWr(3'h1, 8'h00);
    lockRd(3'h1);
    @(posedge clk) nrst <= 1'h0;
    foreach (lk[i]) lk[i] = 8'h01;
    @(posedge clk) nrst <= 1'h1;
    lockRd(3'h1);
    stat(8'h80);
    conclude;
  end
endmodule // flash_status_and_block_lock_tb

// *** tb/fsbl_algo_model.sv ***
`timescale 1ns/1ps
// Stand-in for the program/erase algorithm: counts down, then reports done.
module fsbl_algo_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic opGranted,
  input wire logic suspendReq,
  input wire logic resumeCmd,
  input wire logic [7:0] lat,
  input wire logic failSel,
  output logic opDone,
  output logic opFail,
  output logic pauseReached
);
  logic [7:0] cnt_ff;
  logic run_ff;
  // It pauses at once, so a nested program restarts the count and a resumed erase ends fast.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {cnt_ff, run_ff, opDone, opFail, pauseReached} <= '0;
    end else begin
      opDone <= 1'h0;
      opFail <= 1'h0;
      pauseReached <= suspendReq & run_ff;
      if (opGranted) begin
        run_ff <= 1'h1;
        cnt_ff <= lat;
      end else if (suspendReq | resumeCmd) begin
        run_ff <= resumeCmd;
      end else if (run_ff && cnt_ff == 8'h00) begin
        run_ff <= 1'h0;
        opDone <= 1'h1;
        opFail <= failSel;
      end else if (run_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule // fsbl_algo_model
